// [pkg/mam_pkg.sv]
package mam_pkg;

  // control clock
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;

  // operator link supervision times
  localparam int unsigned INIT_LINK_MS   = 5000;
  localparam int unsigned ONLINE_LINK_MS = 2000;
  localparam int unsigned INIT_LINK_CYC  = INIT_LINK_MS * CYC_PER_MS;
  localparam int unsigned ONLINE_LINK_CYC = ONLINE_LINK_MS * CYC_PER_MS;

  // alarm display blink half period
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;

  // link supervision timer width
  localparam int unsigned LINK_TMR_W     = 32;

  // comm error stop method field: keep running when bits [3:2] are 11
  localparam int unsigned STOP_METHOD_W  = 4;
  localparam int unsigned KEEP_RUN_MSB   = 3;
  localparam int unsigned KEEP_RUN_LSB   = 2;
  localparam logic [1:0]  KEEP_RUN_CODE  = 2'h3;

  // parameter fault categories, lowest index reported first
  localparam int unsigned PCAT_N         = 5;
  localparam int unsigned PCAT_CAPACITY  = 0;
  localparam int unsigned PCAT_RANGE     = 1;
  localparam int unsigned PCAT_INPUT     = 2;
  localparam int unsigned PCAT_VF        = 3;
  localparam int unsigned PCAT_CARRIER   = 4;

  // reset values
  localparam logic [PCAT_N-1:0] PCAT_NONE = 5'h00;

  // operator link supervision states
  typedef enum logic [1:0] {
    MAM_LINK_WAIT,
    MAM_LINK_UP,
    MAM_LINK_INIT_FAIL,
    MAM_LINK_LOST
  } mam_link_state_t;

endpackage

// [rtl/mam_blinker.sv]
`timescale 1ns/1ps
module mam_blinker
#(
  parameter int unsigned HALF_CYC = mam_pkg::BLINK_HALF_CYC
)
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      phase
);
  import mam_pkg::*;

  localparam int unsigned CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_phase;

  // free running divider, shared by every blinking alarm so they stay in step
  always_comb
  begin
    next_cnt   = cnt + 1'b1;
    next_phase = phase;
    if (cnt == CW'(HALF_CYC - 1))
    begin
      next_cnt   = '0;
      next_phase = ~phase;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt   <= '0;
      phase <= 1'b0;
    end
    else
    begin
      cnt   <= next_cnt;
      phase <= next_phase;
    end
  end

endmodule

// [rtl/mam_monitor.sv]
// Functional notes
// - initial link alarm after 5 s silence
// - online link alarm after 2 s failures
// - block input stops output, blinks alarm
// - release resumes output at prior reference
// - check parameters at power-up, leaving program
// - keep running, blink fault-1 on comm error
// - keep running, blink fault-2 on protocol error
// - ready-waiting shown until good master data
`timescale 1ns/1ps
module mam_monitor
#(
  parameter int unsigned INIT_CYC   = mam_pkg::INIT_LINK_CYC,
  parameter int unsigned ONLINE_CYC = mam_pkg::ONLINE_LINK_CYC,
  parameter int unsigned BLINK_CYC  = mam_pkg::BLINK_HALF_CYC,
  parameter int unsigned FREQ_W     = 16
)
(
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  input  wire logic                           op_xfer_ok,
  input  wire logic                           output_block_pin,
  input  wire logic [FREQ_W-1:0]              freq_ref_in,
  input  wire logic                           program_mode,
  input  wire logic [mam_pkg::PCAT_N-1:0]     param_bad,
  input  wire logic [mam_pkg::STOP_METHOD_W-1:0] comm_error_stop_method,
  input  wire logic                           fb_comm_err,
  input  wire logic                           fb_proto_err,
  input  wire logic                           fb_msg_good,
  input  wire logic                           fb_alarm_ack,
  input  wire logic                           option_card_fitted,
  input  wire logic                           major_fault,
  output logic                                operator_initial_link_alarm,
  output logic                                operator_online_link_alarm,
  output logic                                output_block_alarm,
  output logic                                out_enable,
  output logic [FREQ_W-1:0]                   freq_ref_out,
  output logic                                capacity_setting_alarm,
  output logic                                range_setting_alarm,
  output logic                                input_terminal_setting_alarm,
  output logic                                vf_curve_setting_alarm,
  output logic                                carrier_freq_setting_alarm,
  output logic                                fieldbus_fault_one_alarm,
  output logic                                fieldbus_fault_two_alarm,
  output logic                                fieldbus_ready_waiting,
  output logic                                fault_contact
);
  import mam_pkg::*;

  logic                    rst_meta;
  logic                    rst_n;
  logic                    blk_meta;
  logic                    blk_sync;
  logic                    blink;
  mam_link_state_t         link_st;
  mam_link_state_t         next_link_st;
  logic [LINK_TMR_W-1:0]   link_tmr;
  logic [LINK_TMR_W-1:0]   next_link_tmr;
  logic                    booted;
  logic                    prog_prev;
  logic [PCAT_N-1:0]       pcat;
  logic [PCAT_N-1:0]       next_pcat;
  logic                    fb1_flag;
  logic                    fb2_flag;
  logic                    next_fb1_flag;
  logic                    next_fb2_flag;
  logic                    msg_seen;
  logic                    keep_run;
  logic                    chk_req;

  // every check runs on the control clock and sleeps while in reset
  default clocking chk_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // lowest bad category wins so at most one is shown
  function automatic logic [PCAT_N-1:0] first_bad(input logic [PCAT_N-1:0] v);
    first_bad = v & (~v + 1'b1);
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // block pin is asynchronous to the control clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blk_meta <= 1'b0;
      blk_sync <= 1'b0;
    end
    else
    begin
      blk_meta <= output_block_pin;
      blk_sync <= blk_meta;
    end
  end

  mam_blinker #(
    .HALF_CYC (BLINK_CYC)
  ) u_blink (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .phase    (blink)
  );

  // operator link supervision; timer counts cycles since last good exchange
  always_comb
  begin
    next_link_st  = link_st;
    next_link_tmr = link_tmr;
    if (op_xfer_ok)
    begin
      next_link_st  = MAM_LINK_UP;
      next_link_tmr = '0;
    end
    else
    begin
      if (link_tmr != '1)
        next_link_tmr = link_tmr + 1'b1;
      unique case (link_st)
        MAM_LINK_WAIT:
          if (link_tmr >= LINK_TMR_W'(INIT_CYC - 1))
            next_link_st = MAM_LINK_INIT_FAIL;
        MAM_LINK_UP:
          if (link_tmr >= LINK_TMR_W'(ONLINE_CYC))
            next_link_st = MAM_LINK_LOST;
        MAM_LINK_INIT_FAIL,
        MAM_LINK_LOST:
          next_link_st = link_st;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_st  <= MAM_LINK_WAIT;
      link_tmr <= '0;
    end
    else
    begin
      link_st  <= next_link_st;
      link_tmr <= next_link_tmr;
    end
  end

  // parameter check at first cycle out of reset and on leaving program mode
  assign chk_req = !booted || (prog_prev && !program_mode);

  // fieldbus faults only flagged while the stop method keeps running
  assign keep_run =
    comm_error_stop_method[KEEP_RUN_MSB:KEEP_RUN_LSB] == KEEP_RUN_CODE;

  // next check result and fault flags; set wins over acknowledge
  always_comb
  begin
    next_pcat     = pcat;
    next_fb1_flag = fb1_flag;
    next_fb2_flag = fb2_flag;
    if (chk_req)
      next_pcat = first_bad(param_bad);
    if (fb_alarm_ack)
    begin
      next_fb1_flag = 1'b0;
      next_fb2_flag = 1'b0;
    end
    if (fb_comm_err && keep_run)
      next_fb1_flag = 1'b1;
    if (fb_proto_err && keep_run)
      next_fb2_flag = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      booted    <= 1'b0;
      prog_prev <= 1'b0;
      pcat      <= PCAT_NONE;
      fb1_flag  <= 1'b0;
      fb2_flag  <= 1'b0;
      msg_seen  <= 1'b0;
    end
    else
    begin
      booted    <= 1'b1;
      prog_prev <= program_mode;
      pcat      <= next_pcat;
      fb1_flag  <= next_fb1_flag;
      fb2_flag  <= next_fb2_flag;
      msg_seen  <= msg_seen || fb_msg_good;
    end
  end

  // every output registered; blinking alarms gated by the shared phase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      operator_initial_link_alarm  <= 1'b0;
      operator_online_link_alarm   <= 1'b0;
      output_block_alarm           <= 1'b0;
      out_enable                   <= 1'b0;
      freq_ref_out                 <= '0;
      capacity_setting_alarm       <= 1'b0;
      range_setting_alarm          <= 1'b0;
      input_terminal_setting_alarm <= 1'b0;
      vf_curve_setting_alarm       <= 1'b0;
      carrier_freq_setting_alarm   <= 1'b0;
      fieldbus_fault_one_alarm     <= 1'b0;
      fieldbus_fault_two_alarm     <= 1'b0;
      fieldbus_ready_waiting       <= 1'b0;
      fault_contact                <= 1'b0;
    end
    else
    begin
      operator_initial_link_alarm  <= next_link_st == MAM_LINK_INIT_FAIL;
      operator_online_link_alarm   <= next_link_st == MAM_LINK_LOST;
      output_block_alarm           <= blk_sync && blink;
      out_enable                   <= !blk_sync;
      // held until the stage is back on, so release resumes at the old value
      if (!blk_sync && out_enable)
        freq_ref_out <= freq_ref_in;
      capacity_setting_alarm       <= next_pcat[PCAT_CAPACITY];
      range_setting_alarm          <= next_pcat[PCAT_RANGE];
      input_terminal_setting_alarm <= next_pcat[PCAT_INPUT];
      vf_curve_setting_alarm       <= next_pcat[PCAT_VF];
      carrier_freq_setting_alarm   <= next_pcat[PCAT_CARRIER];
      fieldbus_fault_one_alarm     <= next_fb1_flag && blink;
      fieldbus_fault_two_alarm     <= next_fb2_flag && blink;
      fieldbus_ready_waiting       <= option_card_fitted &&
                                      !(msg_seen || fb_msg_good);
      // minor alarms never reach the contact
      fault_contact                <= major_fault;
    end
  end

  // checks; clock and reset come from the defaults at the top
  chk_init_timeout: assert property (
    link_st == MAM_LINK_WAIT && !op_xfer_ok
    && link_tmr == LINK_TMR_W'(INIT_CYC - 1) |=> operator_initial_link_alarm)
    else $error("initial link alarm missing at timeout");
  chk_init_cause: assert property (
    $rose(operator_initial_link_alarm)
    |-> $past(link_tmr) >= LINK_TMR_W'(INIT_CYC - 1))
    else $error("initial link alarm raised early");
  chk_online_lost: assert property (
    $rose(operator_online_link_alarm) |-> $past(link_st) == MAM_LINK_UP
    && $past(link_tmr) >= LINK_TMR_W'(ONLINE_CYC))
    else $error("online link alarm without 2 s of failures");
  chk_block_off: assert property (blk_sync |=> !out_enable)
    else $error("output not disabled while blocked");
  chk_block_resume: assert property (
    $fell(blk_sync) |=> out_enable && freq_ref_out == $past(freq_ref_out))
    else $error("output not resumed at held reference");
  chk_param_one: assert property (
    $onehot0({capacity_setting_alarm, range_setting_alarm,
              input_terminal_setting_alarm, vf_curve_setting_alarm,
              carrier_freq_setting_alarm}))
    else $error("more than one setting alarm shown");
  chk_param_hold: assert property (
    booted && !(prog_prev && !program_mode) |=> $stable(pcat))
    else $error("setting alarms changed outside a check");
  chk_fb_one_set: assert property (
    fb_comm_err && keep_run |=> fb1_flag)
    else $error("fault-1 not flagged");
  chk_fb_two_gate: assert property (
    $rose(fb2_flag) |-> $past(fb_proto_err && keep_run))
    else $error("fault-2 flagged without cause");
  chk_ready_clear: assert property (
    fb_msg_good |=> !fieldbus_ready_waiting [*2])
    else $error("ready-waiting not cleared by good message");
  chk_contact_major: assert property (
    fault_contact == $past(major_fault))
    else $error("fault contact not following major fault");

  cov_link_up: cover property (
    link_st == MAM_LINK_WAIT ##1 link_st == MAM_LINK_UP);
  cov_block: cover property ($rose(blk_sync) ##[1:30] $fell(blk_sync));
  cov_param: cover property ($rose(vf_curve_setting_alarm));
  cov_fb_one: cover property ($rose(fb1_flag));

endmodule

// [test/mam_far_model.sv]
`timescale 1ns/1ps
// stand-in for the operator panel and the fieldbus master
module mam_far_model
(
  input  wire logic       core_clk,
  input  wire logic       panel_on,
  input  wire logic [3:0] gap,
  input  wire logic [1:0] fb_req,
  input  wire logic       fb_go,
  output logic            op_xfer_ok,
  output logic            fb_msg_good,
  output logic            fb_comm_err,
  output logic            fb_proto_err
);
  logic [3:0] cnt;

  initial
  begin
    cnt = 4'h0;
    op_xfer_ok = 1'b0;
    fb_msg_good = 1'b0;
    fb_comm_err = 1'b0;
    fb_proto_err = 1'b0;
  end

  // panel answers every gap+1 cycles; an unplugged panel never answers
  always @(posedge core_clk)
  begin
    cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
    op_xfer_ok <= panel_on && (cnt >= gap);
    fb_msg_good <= fb_go && (fb_req == 2'h1);
    fb_comm_err <= fb_go && (fb_req == 2'h2);
    fb_proto_err <= fb_go && (fb_req == 2'h3);
  end
endmodule

// [test/minor_alarm_monitor_test.sv]
`timescale 1ns/1ps
module minor_alarm_monitor_test;
  logic        core_clk = 1'b0;
  logic        rstn, op_xfer_ok, pin, prog, fb_comm_err, fb_proto_err;
  logic        fb_msg_good, ack, card, major, panel_on, fb_go;
  logic [15:0] freq_in, freq_out, f0;
  logic [4:0]  param_bad, bad;
  logic [3:0]  method, gap;
  logic [1:0]  fb_req;
  logic        init_al, online_al, blk_al, out_en, cap, rng, inp, vf, car;
  logic        fb1, fb2, ready, contact, hi, lo;
  logic [31:0] seed = 32'he022a795;
  logic [31:0] r;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  wire  [4:0]  cat_alarm = {car, vf, inp, rng, cap};

  // 40 ns control clock
  always #20 core_clk = ~core_clk;

  mam_far_model FAR (.core_clk(core_clk), .panel_on(panel_on), .gap(gap),
    .fb_req(fb_req), .fb_go(fb_go), .op_xfer_ok(op_xfer_ok),
    .fb_msg_good(fb_msg_good), .fb_comm_err(fb_comm_err),
    .fb_proto_err(fb_proto_err));

  // short counts keep the run brief
  mam_monitor #(.INIT_CYC(50), .ONLINE_CYC(20), .BLINK_CYC(4), .FREQ_W(16))
  DUT (.core_clk(core_clk), .rstn(rstn), .op_xfer_ok(op_xfer_ok),
    .output_block_pin(pin), .freq_ref_in(freq_in), .program_mode(prog),
    .param_bad(param_bad), .comm_error_stop_method(method),
    .fb_comm_err(fb_comm_err), .fb_proto_err(fb_proto_err),
    .fb_msg_good(fb_msg_good), .fb_alarm_ack(ack),
    .option_card_fitted(card), .major_fault(major),
    .operator_initial_link_alarm(init_al),
    .operator_online_link_alarm(online_al), .output_block_alarm(blk_al),
    .out_enable(out_en), .freq_ref_out(freq_out),
    .capacity_setting_alarm(cap), .range_setting_alarm(rng),
    .input_terminal_setting_alarm(inp), .vf_curve_setting_alarm(vf),
    .carrier_freq_setting_alarm(car), .fieldbus_fault_one_alarm(fb1),
    .fieldbus_fault_two_alarm(fb2), .fieldbus_ready_waiting(ready),
    .fault_contact(contact));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // only the lowest bad category is reported
  function automatic logic [4:0] exp_cat(input logic [4:0] b);
    return b & (~b + 5'h01);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // blinking shows as both levels within a window
  task automatic watch(input int sel, input int n);
    logic v;
    hi = 1'b0;
    lo = 1'b0;
    repeat (n)
    begin
      @(negedge core_clk);
      v = (sel == 0) ? blk_al : (sel == 1) ? fb1 : fb2;
      if (v === 1'b1) hi = 1'b1;
      if (v === 1'b0) lo = 1'b1;
    end
  endtask

  task automatic fire(input logic [1:0] k);
    fb_req = k;
    fb_go = 1'b1;
    tick(1);
    fb_go = 1'b0;
    tick(3);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      print_verdict();
    end
  end

  initial
  begin
    rstn = 1'b0; pin = 1'b0; prog = 1'b0; param_bad = 5'h06; method = 4'h0;
    ack = 1'b0; card = 1'b1; major = 1'b0; freq_in = 16'h0000;
    panel_on = 1'b0; gap = 4'h4; fb_req = 2'h0; fb_go = 1'b0;
    tick(10);
    rstn = 1'b1;
    tick(3);
    chk(cat_alarm, exp_cat(5'h06));
    chk(ready, 1'b1);
    card = 1'b0;
    tick(2);
    chk(ready, 1'b0);
    card = 1'b1;
    tick(35);
    chk(init_al, 1'b0);
    tick(20);
    chk(init_al, 1'b1);
    chk(contact, 1'b0);
    r = rnd();
    gap = 4'h2 + {2'h0, r[1:0]};
    panel_on = 1'b1;
    tick(12);
    chk({init_al, online_al}, 2'h0);
    panel_on = 1'b0;
    tick(10);
    chk(online_al, 1'b0);
    tick(16);
    chk(online_al, 1'b1);
    chk(contact, 1'b0);
    panel_on = 1'b1;
    tick(12);
    chk(online_al, 1'b0);
    $display("test link done");
    r = rnd();
    f0 = r[15:0];
    freq_in = f0;
    tick(3);
    pin = 1'b1;
    tick(5);
    chk(out_en, 1'b0);
    r = rnd();
    freq_in = r[15:0];
    tick(3);
    chk(freq_out, f0);
    watch(0, 12);
    chk({hi, lo}, 2'h3);
    chk(contact, 1'b0);
    pin = 1'b0;
    tick(3);
    chk({out_en, freq_out}, {1'b1, f0});
    tick(2);
    chk(freq_out, freq_in);
    watch(0, 10);
    chk({hi, lo}, 2'h1);
    $display("test block done");
    for (int k = 0; k <= 5; k++)
    begin
      r = rnd();
      bad = (r[4:0] | (5'h01 << k)) & (5'h1F << k);
      prog = 1'b1;
      param_bad = bad;
      tick(2);
      prog = 1'b0;
      tick(2);
      chk(cat_alarm, exp_cat(bad));
    end
    $display("test params done");
    chk(ready, 1'b1);
    fire(2'h1);
    chk(ready, 1'b0);
    $display("test ready done");
    for (int k = 0; k < 2; k++)
    begin
      r = rnd();
      method = 4'hC | r[3:0];
      fire(2'h2 + k[1:0]);
      watch(1 + k, 12);
      chk({hi, lo, out_en}, 3'h7);
      ack = 1'b1;
      tick(1);
      ack = 1'b0;
      watch(1 + k, 12);
      chk({hi, lo}, 2'h1);
      fb_req = 2'h2 + k[1:0];
      fb_go = 1'b1;
      tick(1);
      fb_go = 1'b0;
      ack = 1'b1;
      tick(1);
      ack = 1'b0;
      watch(1 + k, 12);
      chk({hi, lo}, 2'h3);
      ack = 1'b1;
      tick(1);
      ack = 1'b0;
      method = r[7:4] & 4'h7;
      fire(2'h2 + k[1:0]);
      watch(1 + k, 12);
      chk({hi, lo}, 2'h1);
    end
    chk({contact, ready}, 2'h0);
    $display("test fieldbus done");
    major = 1'b1;
    tick(2);
    chk(contact, 1'b1);
    major = 1'b0;
    tick(2);
    chk(contact, 1'b0);
    $display("test contact done");
    print_verdict();
  end
endmodule
